/* pkg/sync_serial_if.sv */
// Link wires between the documented device and its partner IC.
// Assumes the bench supplies pclk; the shared clock pin is resolved here.
`timescale 1ns/10ps
interface sync_serial_if;
    logic dev_clk_out;
    logic dev_clk_oe;
    logic ptr_clk_out;
    logic ptr_clk_oe;
    logic transfer_clock_pin;
    logic alt_clock_out_pin;
    logic serial_out_pin;
    logic serial_in_pin;
    logic receive_ready_out;
    logic clear_to_send_in;

    // Undriven pin floats high through a pull-up
    assign transfer_clock_pin = dev_clk_oe ? dev_clk_out : (ptr_clk_oe ? ptr_clk_out : 1'b1);

    modport device (
        output dev_clk_out, dev_clk_oe, alt_clock_out_pin, serial_out_pin, receive_ready_out,
        input  transfer_clock_pin, serial_in_pin, clear_to_send_in
    );
    modport partner (
        output ptr_clk_out, ptr_clk_oe, serial_in_pin, clear_to_send_in,
        input  transfer_clock_pin, serial_out_pin, receive_ready_out
    );
endinterface // sync_serial_if

/* pkg/sync_serial_pkg.sv */
// Constants and types shared by both ends of the clocked serial channel.
// Assumes one clock (pclk) for both ends and APB for the device registers.
//
// How it works
// - Transmit enable arms the transmitter
// - First falling edge loads shifter, drives bit
// - Remaining bits out per falling edge, LSB first
// - Byte done: register-empty flag set, clock high
// - Complete cause raises transmit request on finish
// - Route bits both one: clock on alternate pin
// - Software changes clock pin only when halted
// - Alternate pin: channel one, internal, handshake disabled
// - Clock from divide 1/8/32 or external pin
// - Polarity swaps launch and sample edges
// - Dummy data plus both enables: ready output low; code drops it on receive enable alone while no byte is in flight
// - Partner clocks only after ready goes low
// - First rising edge captures input into MSB
// - Later rising edges shift right, capture top
// - Full byte copied to buffer, clock high
// - Copy sets receive done flag and request
// - Reading receive buffer clears done flag
// - Reception runs the transmitter with dummy data
// - Overrun flag on unread buffer, request untouched
// - Ready high while receiving, low when done
package sync_serial_pkg;
    localparam int        BYTE_W        = 8;
    typedef logic [BYTE_W-1:0] byte_t;

    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_TXBUF   = 8'h04;
    localparam logic [7:0] ADDR_RXBUF   = 8'h08;
    localparam logic [7:0] ADDR_STATUS  = 8'h0c;

    // Control word fields
    localparam int        CTRL_W        = 11;
    localparam int        CTRL_TX_EN    = 0;
    localparam int        CTRL_RX_EN    = 1;
    localparam int        CTRL_SRC_LO   = 2;
    localparam int        CTRL_POL      = 4;
    localparam int        CTRL_MSB      = 5;
    localparam int        CTRL_TXI_DONE = 6;
    localparam int        CTRL_ROUTE_LO = 7;
    localparam int        CTRL_RTS_DIS  = 9;
    localparam int        CTRL_CTS_EN   = 10;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;

    // Status word fields
    localparam int        ST_TXBUF_EMPTY = 0;
    localparam int        ST_TXREG_EMPTY = 1;
    localparam int        ST_RX_DONE     = 2;
    localparam int        ST_OVERRUN     = 3;
    localparam int        ST_TX_IRQ      = 4;
    localparam int        ST_RX_IRQ      = 5;
    localparam int        ST_BUSY        = 6;

    typedef enum logic [1:0] {SRC_F1, SRC_F8, SRC_F32, SRC_EXT} clk_src_e;
    typedef enum logic {LINK_IDLE, LINK_RUN} link_state_e;

    localparam int        DIV_W         = 6;
    localparam logic [DIV_W-1:0] DIV_F1  = 6'h01;
    localparam logic [DIV_W-1:0] DIV_F8  = 6'h08;
    localparam logic [DIV_W-1:0] DIV_F32 = 6'h20;
    localparam logic [1:0] ROUTE_ALT    = 2'h3;
    localparam logic [2:0] LAST_BIT     = 3'h7;
    localparam clk_src_e  PARTNER_SRC   = SRC_F8;
endpackage

/* rtl/serial_device_end.sv */
// Documented device end: APB register file plus clocked serial engine.
// Assumes APB requests on pclk and a partner on the link interface.
`timescale 1ns/10ps
module serial_device_end
    import sync_serial_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    sync_serial_if.device    link
);
    ////////////////////////////////////////////////////////////////////////////
    // Registers and state
    logic [CTRL_W-1:0] ctrl_q;
    byte_t             txbuf_q;
    byte_t             rxbuf_q;
    byte_t             tx_q;
    byte_t             rx_q;
    logic              txbuf_empty_q;
    logic              txreg_empty_q;
    logic              rx_done_q;
    logic              overrun_q;
    logic              tx_irq_q;
    logic              rx_irq_q;
    link_state_e       state_q;
    logic [2:0]        cnt_q;
    logic              loaded_q;
    logic              raw_q;
    logic              pin_prev_q;
    logic [1:0]        route_q;
    logic              out_q;
    logic              clk_q;
    logic              clk_oe_q;
    logic              alt_q;
    logic              rts_q;

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    logic        tx_en, rx_en, pol, msb, txi_done, rts_dis, cts_en, ext;
    clk_src_e    src;
    logic        access, commit, hit_ctrl, hit_tx, hit_rx, hit_st, mapped;
    logic        wr_ctrl, wr_tx, rd_rx, wr_st;
    logic [31:0] rd_mux;
    logic [6:0]  status;

    assign tx_en    = ctrl_q[CTRL_TX_EN];
    assign rx_en    = ctrl_q[CTRL_RX_EN];
    assign src      = clk_src_e'(ctrl_q[CTRL_SRC_LO +: 2]);
    assign pol      = ctrl_q[CTRL_POL];
    assign msb      = ctrl_q[CTRL_MSB];
    assign txi_done = ctrl_q[CTRL_TXI_DONE];
    assign rts_dis  = ctrl_q[CTRL_RTS_DIS];
    assign cts_en   = ctrl_q[CTRL_CTS_EN];
    assign ext      = (src == SRC_EXT);

    assign access   = psel && penable;
    assign commit   = access && pready;
    assign hit_ctrl = paddr == ADDR_CTRL;
    assign hit_tx   = paddr == ADDR_TXBUF;
    assign hit_rx   = paddr == ADDR_RXBUF;
    assign hit_st   = paddr == ADDR_STATUS;
    assign mapped   = hit_ctrl || hit_tx || hit_rx || hit_st;
    assign wr_ctrl  = commit && pwrite && hit_ctrl;
    assign wr_tx    = commit && pwrite && hit_tx;
    assign rd_rx    = commit && !pwrite && hit_rx;
    assign wr_st    = commit && pwrite && hit_st;

    assign status = {state_q == LINK_RUN, rx_irq_q, tx_irq_q, overrun_q,
                     rx_done_q, txreg_empty_q, txbuf_empty_q};
    assign rd_mux = hit_ctrl ? {21'h000000, ctrl_q} :
                    hit_tx   ? {24'h000000, txbuf_q} :
                    hit_rx   ? {24'h000000, rxbuf_q} :
                    hit_st   ? {25'h0000000, status} : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////
    // Shift clock edges
    logic  tick, pin_raw, launch, sample, load, done, rx_set, cts_ok, start;
    logic  raw_next;
    byte_t tx_next, rx_next;

    shift_clock_divider u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (state_q == LINK_RUN && !ext),
        .src     (src),
        .tick    (tick)
    );

    // Launch is the falling edge of the polarity-corrected clock
    assign pin_raw  = link.transfer_clock_pin ^ pol;
    assign launch   = (state_q == LINK_RUN) && (ext ? (pin_prev_q && !pin_raw) : (tick && raw_q));
    assign sample   = (state_q == LINK_RUN) && loaded_q &&
                      (ext ? (!pin_prev_q && pin_raw) : (tick && !raw_q));
    assign load     = launch && !loaded_q;
    assign done     = sample && cnt_q == LAST_BIT;
    assign rx_set   = done && rx_en;
    assign cts_ok   = !cts_en || rts_dis || !link.clear_to_send_in;
    // Reception also needs the transmitter armed with dummy data
    assign start    = tx_en && !txbuf_empty_q && cts_ok;
    assign raw_next = (state_q == LINK_RUN && !ext && tick) ? !raw_q : raw_q;
    assign tx_next  = msb ? {tx_q[BYTE_W-2:0], 1'b0} : {1'b0, tx_q[BYTE_W-1:1]};
    assign rx_next  = msb ? {rx_q[BYTE_W-2:0], link.serial_in_pin}
                          : {link.serial_in_pin, rx_q[BYTE_W-1:1]};

    assign link.dev_clk_out       = clk_q;
    assign link.dev_clk_oe        = clk_oe_q;
    assign link.alt_clock_out_pin = alt_q;
    assign link.serial_out_pin    = out_q;
    assign link.receive_ready_out = rts_q;

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            ctrl_q  <= CTRL_RESET;
            txbuf_q <= '0;
        end else begin
            pready  <= access && !pready;
            pslverr <= access && !pready && !mapped;
            prdata  <= (access && !pready && !pwrite) ? rd_mux : 32'h00000000;
            if (wr_ctrl) begin
                ctrl_q <= pwdata[CTRL_W-1:0];
            end
            if (wr_tx) begin
                txbuf_q <= pwdata[BYTE_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flags: a hardware set beats a software clear in the same cycle, but a TXBUF write beats load on txbuf_empty_q
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txbuf_empty_q <= 1'b1;
            txreg_empty_q <= 1'b1;
            rx_done_q     <= 1'b0;
            overrun_q     <= 1'b0;
            tx_irq_q      <= 1'b0;
            rx_irq_q      <= 1'b0;
            rxbuf_q       <= '0;
        end else begin
            if (wr_tx) begin
                txbuf_empty_q <= 1'b0;
            end else if (load) begin
                txbuf_empty_q <= 1'b1;
            end
            if (done) begin
                txreg_empty_q <= 1'b1;
            end else if (load) begin
                txreg_empty_q <= 1'b0;
            end
            if ((txi_done && done) || (!txi_done && load)) begin
                tx_irq_q <= 1'b1;
            end else if (wr_st && pwdata[ST_TX_IRQ]) begin
                tx_irq_q <= 1'b0;
            end
            if (rx_set) begin
                rxbuf_q   <= rx_next;
                rx_done_q <= 1'b1;
            end else if (rd_rx) begin
                rx_done_q <= 1'b0;
            end
            if (rx_set && rx_done_q) begin
                overrun_q <= 1'b1;
            end else if (wr_st && pwdata[ST_OVERRUN]) begin
                overrun_q <= 1'b0;
            end
            if (rx_set && !rx_done_q) begin
                rx_irq_q <= 1'b1;
            end else if (wr_st && pwdata[ST_RX_IRQ]) begin
                rx_irq_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= LINK_IDLE;
            cnt_q      <= '0;
            loaded_q   <= 1'b0;
            raw_q      <= 1'b1;
            pin_prev_q <= 1'b1;
            tx_q       <= '0;
            rx_q       <= '0;
            route_q    <= '0;
            out_q      <= 1'b1;
        end else begin
            pin_prev_q <= pin_raw;
            raw_q      <= raw_next;
            unique case (state_q)
                LINK_IDLE: begin
                    // Route only follows software while halted
                    route_q <= ctrl_q[CTRL_ROUTE_LO +: 2];
                    if (start) begin
                        state_q <= LINK_RUN;
                    end
                end
                LINK_RUN: begin
                    // Back-to-back byte if the buffer was refilled in time
                    if (done && !(start && !wr_tx)) begin
                        state_q <= LINK_IDLE;
                    end
                end
            endcase
            if (launch) begin
                loaded_q <= 1'b1;
                if (loaded_q) begin
                    tx_q  <= tx_next;
                    out_q <= msb ? tx_next[BYTE_W-1] : tx_next[0];
                end else begin
                    tx_q  <= txbuf_q;
                    out_q <= msb ? txbuf_q[BYTE_W-1] : txbuf_q[0];
                end
            end
            if (sample) begin
                rx_q  <= rx_next;
                cnt_q <= cnt_q + 3'h1;
            end
            if (done) begin
                loaded_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers; idle clock parks high after the last rising edge
    logic alt_on;
    assign alt_on = route_q == ROUTE_ALT && !ext && rts_dis;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_q    <= 1'b1;
            clk_oe_q <= 1'b0;
            alt_q    <= 1'b1;
            rts_q    <= 1'b1;
        end else begin
            clk_oe_q <= !ext;
            clk_q    <= (alt_on ? 1'b1 : raw_next) ^ pol;
            alt_q    <= (alt_on ? raw_next : 1'b1) ^ pol;
            // High from first launch until the byte is in
            rts_q    <= rts_dis || !rx_en || load || (loaded_q && !done);
        end
    end
endmodule // serial_device_end

/* rtl/serial_partner_end.sv */
// Partner IC end: exchanges one byte per frame with the device.
// Assumes the device end sits on the same link and the same pclk.
`timescale 1ns/10ps
module serial_partner_end
    import sync_serial_pkg::*;
(
    input  wire logic      pclk,
    input  wire logic      presetn,
    sync_serial_if.partner link,
    input  wire logic      clk_master,
    input  wire logic      polarity,
    input  wire logic      msb_first,
    input  wire byte_t     tx_data,
    input  wire logic      tx_load,
    output byte_t          rx_data,
    output logic           rx_valid,
    output logic           busy
);
    link_state_e state_q;
    byte_t       tx_q;
    byte_t       rx_q;
    logic [2:0]  cnt_q;
    logic        loaded_q;
    logic        raw_q;
    logic        pin_prev_q;
    logic        out_q;
    logic        cts_q;
    logic        clk_q;
    logic        oe_q;
    logic        tick;
    logic        pin_raw;
    logic        launch;
    logic        sample;
    logic        done;
    logic        go;
    byte_t       rx_next;
    byte_t       tx_next;

    shift_clock_divider u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (state_q == LINK_RUN && clk_master),
        .src     (PARTNER_SRC),
        .tick    (tick)
    );

    assign pin_raw = link.transfer_clock_pin ^ polarity;
    assign launch  = (state_q == LINK_RUN) &&
                     (clk_master ? (tick && raw_q) : (pin_prev_q && !pin_raw));
    assign sample  = (state_q == LINK_RUN) && loaded_q &&
                     (clk_master ? (tick && !raw_q) : (!pin_prev_q && pin_raw));
    assign done    = sample && cnt_q == LAST_BIT;
    // Master waits for the receiver's ready output low before clocking
    assign go      = busy && (!clk_master || !link.receive_ready_out);
    assign tx_next = msb_first ? {tx_q[BYTE_W-2:0], 1'b0} : {1'b0, tx_q[BYTE_W-1:1]};
    assign rx_next = msb_first ? {rx_q[BYTE_W-2:0], link.serial_out_pin}
                               : {link.serial_out_pin, rx_q[BYTE_W-1:1]};

    assign link.ptr_clk_out      = clk_q;
    assign link.ptr_clk_oe       = oe_q;
    assign link.serial_in_pin    = out_q;
    assign link.clear_to_send_in = cts_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= LINK_IDLE;
            busy       <= 1'b0;
            tx_q       <= '0;
            rx_q       <= '0;
            rx_data    <= '0;
            rx_valid   <= 1'b0;
            cnt_q      <= '0;
            loaded_q   <= 1'b0;
            raw_q      <= 1'b1;
            pin_prev_q <= 1'b1;
            out_q      <= 1'b1;
            cts_q      <= 1'b1;
            clk_q      <= 1'b1;
            oe_q       <= 1'b0;
        end else begin
            pin_prev_q <= pin_raw;
            rx_valid   <= done;
            cts_q      <= !(busy && !clk_master);
            oe_q       <= clk_master;
            if (tx_load && !busy) begin
                busy <= 1'b1;
                tx_q <= tx_data;
            end else if (done) begin
                busy <= 1'b0;
            end
            if (state_q == LINK_IDLE && go && !tx_load) begin
                state_q <= LINK_RUN;
            end else if (done) begin
                state_q <= LINK_IDLE;
            end
            if (state_q == LINK_RUN && clk_master && tick) begin
                raw_q <= !raw_q;
            end
            clk_q <= ((state_q == LINK_RUN && clk_master && tick) ? !raw_q : raw_q) ^ polarity;
            if (launch) begin
                loaded_q <= 1'b1;
                if (loaded_q) begin
                    tx_q  <= tx_next;
                    out_q <= msb_first ? tx_next[BYTE_W-1] : tx_next[0];
                end else begin
                    out_q <= msb_first ? tx_q[BYTE_W-1] : tx_q[0];
                end
            end
            if (sample) begin
                rx_q  <= rx_next;
                cnt_q <= cnt_q + 3'h1;
            end
            if (done) begin
                loaded_q <= 1'b0;
                rx_data  <= rx_next;
            end
        end
    end
endmodule // serial_partner_end

/* rtl/shift_clock_divider.sv */
// Tick generator dividing pclk by 1, 8 or 32 for the shift clock.
// Assumes run is low between frames so every frame starts phase-aligned.
`timescale 1ns/10ps
module shift_clock_divider
    import sync_serial_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       run,
    input  wire clk_src_e   src,
    output logic            tick
);
    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] limit;

    assign limit = (src == SRC_F32) ? DIV_F32 : ((src == SRC_F8) ? DIV_F8 : DIV_F1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else begin
            tick  <= run && (cnt_q == limit - DIV_F1);
            cnt_q <= (!run || cnt_q == limit - DIV_F1) ? '0 : cnt_q + DIV_F1;
        end
    end
endmodule // shift_clock_divider

/* testbench/sync_serial_chk.sv */
// Link checker: clock, data and handshake timing on the shared wires.
// Assumes polarity 0 framing and one pclk for both ends.
`timescale 1ns/10ps
module sync_serial_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic dev_clk_oe,
    input wire logic ptr_clk_oe,
    input wire logic ptr_clk_out,
    input wire logic transfer_clock_pin,
    input wire logic alt_clock_out_pin,
    input wire logic serial_out_pin,
    input wire logic serial_in_pin,
    input wire logic receive_ready_out
);
    logic       sclk;
    logic [2:0] nrise_q;
    // Either pin may carry the clock; the idle one parks high
    assign sclk = transfer_clock_pin & alt_clock_out_pin;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) nrise_q <= 3'h0;
        else if ($rose(sclk)) nrise_q <= nrise_q + 3'h1;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    launch_on_fall_a: assert property ($changed(serial_out_pin) |-> !sclk)
        else $error("serial data moved while clock high");
    sample_stable_a: assert property ((ptr_clk_oe && $rose(sclk)) |-> $stable(serial_in_pin))
        else $error("input moved at sample edge");
    single_driver_a: assert property (!(dev_clk_oe && ptr_clk_oe))
        else $error("both ends drive the clock");
    alt_exclusive_a: assert property (!(!alt_clock_out_pin && !transfer_clock_pin))
        else $error("clock on both pins");
    partner_waits_a: assert property ((ptr_clk_oe && $fell(ptr_clk_out) && nrise_q == 3'h0) |-> !$past(receive_ready_out))
        else $error("partner clocked before ready low");
    ready_rises_a: assert property (($fell(sclk) && nrise_q == 3'h0) |-> ##[0:2] receive_ready_out)
        else $error("ready not high at frame start");
    ready_held_a: assert property (($rose(sclk) && nrise_q != 3'h7) |-> receive_ready_out)
        else $error("ready low inside frame");
    park_high_a: assert property (($rose(sclk) && nrise_q == 3'h7) |=> sclk [*2])
        else $error("clock not parked high");
    ready_drops_a: assert property ((ptr_clk_oe && $rose(sclk) && nrise_q == 3'h7) |-> ##[0:8] !receive_ready_out)
        else $error("ready not low after byte");
    cover property ($rose(sclk) && nrise_q == 3'h7);
    cover property (ptr_clk_oe && $fell(ptr_clk_out));
    cover property (!alt_clock_out_pin);
endmodule // sync_serial_chk

/* testbench/sync_serial_tx_rx_tb.sv */
// Bench: device and partner ends on one link, APB master, scenarios.
// Assumes both ends share pclk; polarity 0 throughout.
`timescale 1ns/10ps
module sync_serial_tx_rx_tb import sync_serial_pkg::*; ;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, sl, rx_valid, busy;
    logic        clk_master = 1'b0, msb_first = 1'b0, tx_load = 1'b0;
    logic        tclk_q = 1'b1, alt_q = 1'b1, sclk_q = 1'b1, sclk;
    byte_t       tx_data = 8'h00, rx_data, wire_byte;
    int          n_errors, compares, cyc, low_n, last_low, n_main_fall, n_alt_fall;
    sync_serial_if link ();
    serial_device_end i_serial_device_end (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link(link));
    serial_partner_end i_serial_partner_end (.pclk(pclk), .presetn(presetn), .link(link),
        .clk_master(clk_master), .polarity(1'b0), .msb_first(msb_first), .tx_data(tx_data), .tx_load(tx_load),
        .rx_data(rx_data), .rx_valid(rx_valid), .busy(busy));
    sync_serial_chk i_sync_serial_chk (.pclk(pclk), .presetn(presetn), .dev_clk_oe(link.dev_clk_oe),
        .ptr_clk_oe(link.ptr_clk_oe), .ptr_clk_out(link.ptr_clk_out), .transfer_clock_pin(link.transfer_clock_pin),
        .alt_clock_out_pin(link.alt_clock_out_pin), .serial_out_pin(link.serial_out_pin),
        .serial_in_pin(link.serial_in_pin), .receive_ready_out(link.receive_ready_out));
    always #12.5 pclk = ~pclk;
    assign sclk = link.transfer_clock_pin & link.alt_clock_out_pin;
    ////////////////////////////////////////////////////////////////////////////
    // Wire watcher: sample-edge capture, low-phase length, falls per pin
    always @(posedge pclk) begin
        tclk_q <= link.transfer_clock_pin;
        alt_q  <= link.alt_clock_out_pin;
        sclk_q <= sclk;
        cyc    <= cyc + 1;
        if (tclk_q && !link.transfer_clock_pin) n_main_fall <= n_main_fall + 1;
        if (alt_q && !link.alt_clock_out_pin) n_alt_fall <= n_alt_fall + 1;
        if (!sclk) low_n <= low_n + 1;
        if (sclk && !sclk_q) begin
            wire_byte <= {link.serial_out_pin, wire_byte[7:1]};
            last_low  <= low_n;
            low_n     <= 0;
        end
        if (cyc == 30000) begin
            n_errors++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        sl = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // Bounded wait: 0 watches partner byte pulse, 1 watches ready output
    task automatic wait_bit(input int which, input logic v);
        for (int k = 0; k < 3000 && (which == 0 ? rx_valid : link.receive_ready_out) !== v; k++) @(posedge pclk);
        chk({31'h0, which == 0 ? rx_valid : link.receive_ready_out}, {31'h0, v}, "wait timed out");
    endtask
    task automatic arm(input byte_t d);
        tx_data <= d;
        tx_load <= 1'b1;
        @(posedge pclk);
        tx_load <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        chk({31'h0, link.receive_ready_out}, 32'h1, "ready after reset");
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd & 32'h7f, 32'h03, "status reset");
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, 32'h0, "ctrl reset");
        apb(1'b1, 8'h10, 32'hffff);
        chk({31'h0, sl}, 32'h1, "unmapped not refused");
        $display("reset test done");
    endtask
    task automatic test_tx(input logic [1:0] src, input logic msb, input logic cause, input byte_t d);
        int    f0;
        byte_t w;
        f0 = n_main_fall + n_alt_fall;
        w = msb ? {<<{d}} : d;
        msb_first <= msb;
        arm(8'h00);
        apb(1'b1, ADDR_STATUS, 32'h38);
        apb(1'b1, ADDR_CTRL, 32'(1 | (src << CTRL_SRC_LO) | (msb << CTRL_MSB) | (cause << CTRL_TXI_DONE)));
        apb(1'b1, ADDR_TXBUF, {24'h0, d});
        for (int k = 0; k < 300 && n_main_fall + n_alt_fall == f0; k++) @(posedge pclk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd & 32'h11, cause ? 32'h01 : 32'h11, "tx request cause");
        wait_bit(0, 1'b1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd & 32'h13, 32'h13, "tx done flags");
        chk({24'h0, rx_data}, {24'h0, d}, "partner byte");
        chk({24'h0, wire_byte}, {24'h0, w}, "wire bit order");
        chk(32'(last_low), {26'h0, src == 2'h0 ? DIV_F1 : (src == 2'h1 ? DIV_F8 : DIV_F32)}, "half period");
        chk({31'h0, sclk}, 32'h1, "clock not parked");
        $display("tx test done");
    endtask
    task automatic test_alt();
        int m0;
        int a0;
        m0 = n_main_fall;
        a0 = n_alt_fall;
        apb(1'b1, ADDR_CTRL, 32'h0381);
        apb(1'b1, ADDR_TXBUF, 32'h69);
        // Partner only hears the main pin, so wait out one f1 frame
        repeat (40) @(posedge pclk);
        chk({24'h0, wire_byte}, 32'h69, "alt byte");
        chk(32'(n_main_fall - m0), 32'h0, "main pin toggled");
        chk(32'(n_alt_fall - a0), 32'h8, "alt pin edges");
        apb(1'b1, ADDR_CTRL, 32'h0001);
        $display("alt test done");
    endtask
    task automatic rx_frame(input byte_t d);
        apb(1'b1, ADDR_TXBUF, 32'h5a);
        repeat (2) @(posedge pclk);
        chk({31'h0, link.receive_ready_out}, 32'h0, "ready not low");
        arm(d);
        wait_bit(1, 1'b1);
        wait_bit(1, 1'b0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({24'h0, rx_data}, 32'h5a, "dummy on wire");
    endtask
    task automatic test_rx();
        apb(1'b1, ADDR_CTRL, 32'h000f);
        clk_master <= 1'b1;
        rx_frame(8'h3c);
        chk(rd & 32'h2c, 32'h24, "rx flags");
        apb(1'b0, ADDR_RXBUF, 32'h0);
        chk(rd, 32'h3c, "rx byte");
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd & 32'h04, 32'h0, "rx done not cleared");
        rx_frame(8'hc3);
        apb(1'b1, ADDR_STATUS, 32'h20);
        rx_frame(8'h81);
        chk(rd & 32'h2c, 32'h0c, "overrun flags");
        apb(1'b0, ADDR_RXBUF, 32'h0);
        chk(rd, 32'h81, "overrun byte");
        $display("rx test done");
    endtask
    task automatic print_verdict();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_tx(2'h0, 1'b0, 1'b1, 8'ha6);
        test_tx(2'h1, 1'b1, 1'b0, 8'h3c);
        test_tx(2'h2, 1'b0, 1'b1, 8'h81);
        test_alt();
        test_rx();
        print_verdict();
    end
endmodule // sync_serial_tx_rx_tb
